//--- rtl/rft_pkg.sv
// Package of register indices, field positions and carrier types for the reload timers
package rft_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;                   // Byte address width, index times four
  localparam int IDX_W  = 16;                   // Register index width
  localparam int DATA_W = 32;                   // Bus data width
  localparam int CNT_W  = 24;                   // Widest counter handled by helpers

  // ----------------------------------------------------------------
  // Register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_SB_LO      = 16'h00ac; // Second short timer low byte
  localparam logic [IDX_W-1:0] IDX_SB_HI      = 16'h00ad; // Second short timer high byte
  localparam logic [IDX_W-1:0] IDX_SA_LO      = 16'h00ae; // First short timer low byte
  localparam logic [IDX_W-1:0] IDX_SA_HI      = 16'h00af; // First short timer high byte
  localparam logic [IDX_W-1:0] IDX_SHORT_CTL  = 16'h00cf; // Shared short control/status
  localparam logic [IDX_W-1:0] IDX_LONG_CTL   = 16'ha003; // Long control/status
  localparam logic [IDX_W-1:0] IDX_LONG_LO    = 16'ha004; // Long count bits 7:0
  localparam logic [IDX_W-1:0] IDX_LONG_MID   = 16'ha005; // Long count bits 15:8
  localparam logic [IDX_W-1:0] IDX_LONG_TOP   = 16'ha006; // Long count bits 23:16
  localparam logic [IDX_W-1:0] IDX_EVT_STAT   = 16'h0100; // Sticky event status
  localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 16'h0101; // Event mask

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LC_FLAG   = 7;                 // Long overflow flag
  localparam int LC_SEL_HI = 6;                 // Long clock select, upper bit
  localparam int LC_SEL_LO = 5;                 // Long clock select, lower bit
  localparam int LC_MODE   = 4;                 // Long reload select
  localparam int LC_RUN    = 3;                 // Long run
  localparam int LC_IEN    = 0;                 // Long interrupt enable
  localparam int SC_FLAG   = 3;                 // Flag position within a short nibble
  localparam int SC_MODE   = 2;                 // Reload select within a nibble
  localparam int SC_RUN    = 1;                 // Run within a nibble
  localparam int SC_IEN    = 0;                 // Enable within a nibble
  localparam int EVT_W     = 3;                 // Event bits: A, B, long
  localparam int EVT_SA    = 0;                 // First short timer overflow event
  localparam int EVT_SB    = 1;                 // Second short timer overflow event
  localparam int EVT_LONG  = 2;                 // Long timer overflow event
  localparam logic [7:0]       CTL_RST  = 8'h00;     // Control registers reset value
  localparam logic [7:0]       CNT_RST  = 8'h00;     // Count bytes reset value
  localparam logic [EVT_W-1:0] EVT_RST  = 3'h0;      // Event status and mask reset

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flag;                                 // Overflow flag
    logic mode;                                 // 1 auto-reload, 0 free-running
    logic run;                                  // Count enable
    logic ien;                                  // Interrupt enable
  } rft_short_ctl_t;

  typedef struct packed {
    logic       flag;                           // Overflow flag
    logic [1:0] sel;                            // Clock select
    logic       mode;                           // 1 auto-reload, 0 free-running
    logic       run;                            // Count enable
    logic       ien;                            // Interrupt enable
  } rft_long_ctl_t;

endpackage

//--- rtl/rft_timers.sv
// Two short system-clock timers and one long oscillator-driven timer behind APB
//
// Notes on behaviour
// - Two 16-bit up timers on system clock
// - Overflow sets flag; only software clears it
// - Mode bit: 1 auto-reload, 0 free-running
// - Timer counts only while its run bit set
// - Request raised while enable and flag set
// - Flags at bits 7 and 3; reset zero
// - Reload mode writes reload; free mode counter
// - Count reads return live value, no latch
// - 24-bit long timer, free or reload, wakes
// - Select 0x picks fast, 1x slow oscillator
// - Long timer counts only while the system clock runs
// - Long control field layout, unused bits zero
// - Long mode, run and enable bits behave alike
// - Long writes go reload or counter by mode
// - Long count seen as three byte registers
`timescale 1ns/100ps
`default_nettype none

module rft_timers #(
  parameter int SHORT_W = 16,                   // Short timer width
  parameter int LONG_W  = 24                    // Long timer width
) (
  input  wire logic                      sys_clk,    // System clock, 40 MHz
  input  wire logic                      rst,        // Asynchronous reset, active high
  input  wire logic                      psel,       // APB select
  input  wire logic                      penable,    // APB enable
  input  wire logic                      pwrite,     // APB direction
  input  wire logic [rft_pkg::ADDR_W-1:0] paddr,     // APB byte address
  input  wire logic [rft_pkg::DATA_W-1:0] pwdata,    // APB write data
  output logic      [rft_pkg::DATA_W-1:0] prdata,    // APB read data
  output logic                           pready,     // APB ready
  output logic                           pslverr,    // APB error, unmapped address
  input  wire logic                      fastOscIn,  // Fast internal oscillator
  input  wire logic                      slowOscIn,  // Slow internal oscillator
  output logic                           shortAIrq,  // First short timer request
  output logic                           shortBIrq,  // Second short timer request
  output logic                           longIrq,    // Long timer request
  output logic                           irq         // Combined masked event level
);
  import rft_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait states: pready is psel&penable.
  // Read data is captured at the setup edge
  // and stands through the access cycle.
  // Writes land at the access edge only.
  // Unmapped or unaligned: error, data zero.
  // Only byte lane 0 carries register data.
  wire logic [IDX_W-1:0] regIdx   = paddr[ADDR_W-1:2];     // Register index
  wire logic             aligned  = (paddr[1:0] == 2'b00); // Word aligned
  wire logic [7:0]       wrByte   = pwdata[7:0];           // Write byte lane
  wire logic             setupRd  = psel & ~penable;       // Setup phase
  wire logic             accWr    = psel & penable & pwrite;  // Write completes
  wire logic             accRd    = psel & penable & ~pwrite; // Read completes
  wire logic hitSaLo  = aligned & (regIdx == IDX_SA_LO);    // Decode hits
  wire logic hitSaHi  = aligned & (regIdx == IDX_SA_HI);
  wire logic hitSbLo  = aligned & (regIdx == IDX_SB_LO);
  wire logic hitSbHi  = aligned & (regIdx == IDX_SB_HI);
  wire logic hitSCtl  = aligned & (regIdx == IDX_SHORT_CTL);
  wire logic hitLCtl  = aligned & (regIdx == IDX_LONG_CTL);
  wire logic hitLLo   = aligned & (regIdx == IDX_LONG_LO);
  wire logic hitLMid  = aligned & (regIdx == IDX_LONG_MID);
  wire logic hitLTop  = aligned & (regIdx == IDX_LONG_TOP);
  wire logic hitStat  = aligned & (regIdx == IDX_EVT_STAT);
  wire logic hitMask  = aligned & (regIdx == IDX_EVT_MASK);
  wire logic mapped   = hitSaLo | hitSaHi | hitSbLo | hitSbHi | hitSCtl | hitLCtl
                      | hitLLo | hitLMid | hitLTop | hitStat | hitMask;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Helpers run at the widest counter width;
  // short timers widen in and narrow out, so
  // all three timers share one arithmetic.
  // Next count: increment, or on wrap reload / zero
  function automatic logic [CNT_W-1:0] rft_advance(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] rld,
    input logic             wrap,
    input logic             mode
  );
    if (wrap) begin
      return mode ? rld : '0;
    end
    return cnt + CNT_W'(1);
  endfunction

  // Lane 0, 1 or 2 picks bits 7:0, 15:8, 23:16
  // Replace one byte lane of a value
  function automatic logic [CNT_W-1:0] rft_put_byte(
    input logic [CNT_W-1:0] val,
    input logic [1:0]       lane,
    input logic [7:0]       data
  );
    logic [CNT_W-1:0] res;
    res = val;
    res[lane*8 +: 8] = data;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Short timers (index 0 first timer, 1 second timer)
  // ----------------------------------------------------------------
  // One increment per system clock when run.
  // Free mode: a byte write replaces that
  // counter byte and beats the increment.
  // Reload mode: the write hits the reload
  // value; the live count runs on untouched.
  // The shared control byte holds one nibble
  // per timer; a write updates both nibbles.
  // Flags sit at nibble bit 3, set by wrap.
  rft_short_ctl_t      shortCtl_q [2];          // Control nibbles
  logic [SHORT_W-1:0]  shortCnt_q [2];          // Live counters
  logic [SHORT_W-1:0]  shortRld_q [2];          // Reload values
  logic [1:0]          shortWrap;               // Overflow this cycle
  wire logic [1:0]     shortWrLo = {hitSbLo & accWr, hitSaLo & accWr}; // Low byte write
  wire logic [1:0]     shortWrHi = {hitSbHi & accWr, hitSaHi & accWr}; // High byte write
  wire logic           shortCtlWr = hitSCtl & accWr;                  // Control write

  for (genvar i = 0; i < 2; i++) begin : gShort
    wire logic [3:0]         ctlBits = wrByte[i*4 +: 4];              // Written nibble
    wire logic               tick    = shortCtl_q[i].run;
    wire logic [CNT_W-1:0]   cntWide = CNT_W'(shortCnt_q[i]);
    wire logic [CNT_W-1:0]   rldWide = CNT_W'(shortRld_q[i]);
    wire logic [CNT_W-1:0]   advanced;
    wire logic [CNT_W-1:0]   cntNext;
    wire logic [CNT_W-1:0]   rldNext;
    wire logic               wrAny   = shortWrLo[i] | shortWrHi[i];
    wire logic [1:0]         lane    = shortWrHi[i] ? 2'd1 : 2'd0;
    assign shortWrap[i] = tick & (&shortCnt_q[i]);
    assign advanced = tick ? rft_advance(cntWide, rldWide, shortWrap[i],
                                         shortCtl_q[i].mode) : cntWide;
    // Free mode writes hit the counter, reload mode the reload value
    assign cntNext = (wrAny & ~shortCtl_q[i].mode) ?
                     rft_put_byte(advanced, lane, wrByte) : advanced;
    assign rldNext = (wrAny & shortCtl_q[i].mode) ?
                     rft_put_byte(rldWide, lane, wrByte) : rldWide;

    // Run gates the increment only; free-mode
    // byte writes still reach a stopped count.
    // Counter, reload and control nibble
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        shortCnt_q[i] <= '0;
        shortRld_q[i] <= '0;
        shortCtl_q[i] <= rft_short_ctl_t'(CTL_RST[3:0]);
      end else begin
        shortCnt_q[i] <= cntNext[SHORT_W-1:0];
        shortRld_q[i] <= rldNext[SHORT_W-1:0];
        if (shortCtlWr) begin
          shortCtl_q[i].mode <= ctlBits[SC_MODE];
          shortCtl_q[i].run  <= ctlBits[SC_RUN];
          shortCtl_q[i].ien  <= ctlBits[SC_IEN];
        end
        // Hardware set wins over a software clear in the same cycle
        shortCtl_q[i].flag <= shortWrap[i] |
                              (shortCtlWr ? ctlBits[SC_FLAG] : shortCtl_q[i].flag);
      end
    end
  end

  // ----------------------------------------------------------------
  // Long timer oscillator crossing
  // ----------------------------------------------------------------
  // Oscillator pins are unrelated to sys_clk.
  // Two flops synchronise each pin; a third
  // keeps the last level for edge detection.
  // Sources must stay below half of sys_clk.
  // Reset clears to the idle low level, so no
  // false edge follows reset.
  logic [2:0] fastSync_q;                       // Fast oscillator synchroniser + edge stage
  logic [2:0] slowSync_q;                       // Slow oscillator synchroniser + edge stage

  // Two flops, then a third for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fastSync_q <= 3'b000;
      slowSync_q <= 3'b000;
    end else begin
      fastSync_q <= {fastSync_q[1:0], fastOscIn};
      slowSync_q <= {slowSync_q[1:0], slowOscIn};
    end
  end

  wire logic fastRise = fastSync_q[1] & ~fastSync_q[2];                 // Fast edge pulse
  wire logic slowRise = slowSync_q[1] & ~slowSync_q[2];                 // Slow edge pulse

  // ----------------------------------------------------------------
  // Long timer
  // ----------------------------------------------------------------
  // The long timer counts oscillator ticks in
  // the system clock domain, so low power modes
  // keep it going only while sys_clk runs.
  // Select 00/01 is fast, 10/11 slow.
  // Count bytes follow the short timer rules.
  // Bits 2:1 of the control byte read zero.
  rft_long_ctl_t      longCtl_q;                // Long control
  logic [LONG_W-1:0]  longCnt_q;                // Live counter
  logic [LONG_W-1:0]  longRld_q;                // Reload value
  wire logic oscEdge  = longCtl_q.sel[1] ? slowRise : fastRise;
  wire logic longTick = longCtl_q.run & oscEdge;
  wire logic longWrap = longTick & (&longCnt_q);
  wire logic longCtlWr = hitLCtl & accWr;                               // Control write
  wire logic longWr   = (hitLLo | hitLMid | hitLTop) & accWr;           // Count write
  wire logic [1:0] longLane = hitLTop ? 2'd2 : (hitLMid ? 2'd1 : 2'd0);
  wire logic [CNT_W-1:0] longAdv = longTick ?
      rft_advance(CNT_W'(longCnt_q), CNT_W'(longRld_q), longWrap,
                  longCtl_q.mode) : CNT_W'(longCnt_q);
  wire logic [CNT_W-1:0] longCntNext = (longWr & ~longCtl_q.mode) ?
      rft_put_byte(longAdv, longLane, wrByte) : longAdv;
  wire logic [CNT_W-1:0] longRldNext = (longWr & longCtl_q.mode) ?
      rft_put_byte(CNT_W'(longRld_q), longLane, wrByte) : CNT_W'(longRld_q);

  // A clear written to the flag loses to an
  // overflow in the same cycle.
  // Long counter, reload and control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      longCnt_q <= '0;
      longRld_q <= '0;
      longCtl_q <= '0;
    end else begin
      longCnt_q <= longCntNext[LONG_W-1:0];
      longRld_q <= longRldNext[LONG_W-1:0];
      if (longCtlWr) begin
        longCtl_q.sel  <= wrByte[LC_SEL_HI:LC_SEL_LO];
        longCtl_q.mode <= wrByte[LC_MODE];
        longCtl_q.run  <= wrByte[LC_RUN];
        longCtl_q.ien  <= wrByte[LC_IEN];
      end
      longCtl_q.flag <= longWrap | (longCtlWr ? wrByte[LC_FLAG] : longCtl_q.flag);
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt outputs
  // ----------------------------------------------------------------
  // Overflows set sticky status bits. A read
  // clears only the bits that it returned, so
  // an event after the capture edge stays
  // pending; a new event also beats the clear.
  // Mask has the same layout; irq is masked OR.
  logic [EVT_W-1:0] evtStat_q;                  // Sticky events, cleared by read
  logic [EVT_W-1:0] evtMask_q;                  // Event mask
  logic [DATA_W-1:0] prdata_q;                  // Read data captured at setup
  wire logic [EVT_W-1:0] evtSet = {longWrap, shortWrap[1], shortWrap[0]};
  wire logic statRead = hitStat & accRd;        // Read completes, clear
  wire logic [EVT_W-1:0] statClr = statRead ? prdata_q[EVT_W-1:0] : EVT_RST; // Returned bits

  // Set wins over the read clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evtStat_q <= EVT_RST;
      evtMask_q <= EVT_RST;
    end else begin
      evtStat_q <= evtSet | (evtStat_q & ~statClr);
      if (hitMask & accWr) begin
        evtMask_q <= pwdata[EVT_W-1:0];
      end
    end
  end

  // Per-timer requests ignore the event mask.
  assign shortAIrq = shortCtl_q[0].ien & shortCtl_q[0].flag;
  assign shortBIrq = shortCtl_q[1].ien & shortCtl_q[1].flag;
  assign longIrq   = longCtl_q.ien & longCtl_q.flag;
  assign irq       = |(evtStat_q & evtMask_q);

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  // Combinational read mux on the index; the
  // capture flop makes it a registered output.
  // Unused status and mask bits read zero.
  wire logic [7:0] shortCtlByte = {shortCtl_q[1], shortCtl_q[0]};
  wire logic [7:0] longCtlByte  = {longCtl_q.flag, longCtl_q.sel, longCtl_q.mode,
                                   longCtl_q.run, 2'b00, longCtl_q.ien};
  wire logic [CNT_W-1:0] longWide = CNT_W'(longCnt_q);
  wire logic [CNT_W-1:0] saWide   = CNT_W'(shortCnt_q[0]);
  wire logic [CNT_W-1:0] sbWide   = CNT_W'(shortCnt_q[1]);
  // Live values, no snapshot of the other bytes
  wire logic [7:0] rdByte =
      hitSaLo ? saWide[7:0]    : hitSaHi ? saWide[15:8]   :
      hitSbLo ? sbWide[7:0]    : hitSbHi ? sbWide[15:8]   :
      hitLLo  ? longWide[7:0]  : hitLMid ? longWide[15:8] :
      hitLTop ? longWide[23:16] : hitSCtl ? shortCtlByte  :
      hitLCtl ? longCtlByte    : hitStat ? {5'b0, evtStat_q} :
      hitMask ? {5'b0, evtMask_q} : 8'h00;
  logic              pslverr_q;                 // Error captured at setup

  // Error is captured with the data; pslverr
  // is gated low outside the access phase.
  // Capture answer in the setup cycle, present it in the access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setupRd) begin
      prdata_q  <= pwrite ? '0 : DATA_W'(rdByte);
      pslverr_q <= ~mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & psel & penable;
  assign pready  = psel & penable;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Checks watch the decode and registers.
  // Wrap sequences exclude a byte write in the
  // same cycle, which legally overrides the
  // wrapped value.
  sequence shortAWrapS;
    shortWrap[0] && !shortWrLo[0] && !shortWrHi[0];
  endsequence
  sequence shortBWrapS;
    shortWrap[1] && !shortWrLo[1] && !shortWrHi[1];
  endsequence
  sequence longReadSetupS;
    setupRd && !pwrite && hitLLo;
  endsequence

  flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    shortWrap[1] |=> shortCtl_q[1].flag && shortBIrq == shortCtl_q[1].ien)
    else $error("second timer flag not set on overflow");
  flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    longCtl_q.flag && !longCtlWr |=> longCtl_q.flag)
    else $error("long flag cleared without software");
  run_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !shortCtl_q[0].run && !shortWrLo[0] && !shortWrHi[0] |=> $stable(shortCnt_q[0]))
    else $error("stopped timer changed");
  reload_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    shortBWrapS and shortCtl_q[1].mode |=> shortCnt_q[1] == $past(shortRld_q[1]))
    else $error("auto-reload wrap did not load reload value");
  free_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    shortAWrapS and !shortCtl_q[0].mode |=> shortCnt_q[0] == '0)
    else $error("free-running wrap did not restart from zero");
  free_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    shortWrHi[1] && !shortCtl_q[1].mode |=> shortCnt_q[1][15:8] == $past(wrByte))
    else $error("free-running write did not load counter");
  reload_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    longWr && hitLTop && longCtl_q.mode && !longTick
      |=> $stable(longCnt_q) && longRld_q[LONG_W-1 -: 8] == $past(wrByte))
    else $error("reload-mode write disturbed the counter");
  long_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
    longCtl_q.run && !longCtl_q.sel[1] && fastRise && !longWr && !(&longCnt_q)
      |=> longCnt_q == $past(longCnt_q) + LONG_W'(1))
    else $error("fast oscillator edge not counted");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    longWrap && longCtl_q.ien && !longCtlWr |=> longIrq [*2])
    else $error("long request not raised");
  live_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    longReadSetupS |=> prdata[7:0] == $past(longCnt_q[7:0]))
    else $error("long low byte read not live");
  stat_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    statRead && !(|evtSet) |=> (evtStat_q & $past(prdata_q[EVT_W-1:0])) == EVT_RST)
    else $error("event status not cleared by read");
  stat_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    statRead |=> ($past(evtStat_q) & ~$past(prdata_q[EVT_W-1:0]) & ~evtStat_q) == EVT_RST)
    else $error("pending event lost by status read");

endmodule

`default_nettype wire

//--- testbench/test_rft_timers.sv
// Self-checking bench for the reload timers, driven over APB
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin numErrors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_rft_timers;
  import rft_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              sys_clk = 1'b0;      // 40 MHz system clock
  logic              rst     = 1'b1;      // Reset, held at start
  logic              psel    = 1'b0;      // APB select
  logic              penable = 1'b0;      // APB enable
  logic              pwrite  = 1'b0;      // APB direction
  logic [ADDR_W-1:0] paddr   = '0;        // APB byte address
  logic [DATA_W-1:0] pwdata  = '0;        // APB write data
  logic [DATA_W-1:0] prdata;              // APB read data
  logic              pready, pslverr;     // APB answer
  logic              fastOscIn = 1'b0;    // Fast oscillator pin
  logic              slowOscIn = 1'b0;    // Slow oscillator pin
  logic              shortAIrq, shortBIrq, longIrq, irq; // Requests
  logic [3:0]        oscCnt = 4'h0;       // Divider making both oscillators
  logic [7:0]        rdat;                // Last read byte
  logic              rerr;                // Last error response
  logic [1:0]        sel;                 // Long clock select under test
  int                numErrors = 0;       // Mismatches
  int                totalChecks = 0;     // Comparisons made
  int                cycles = 0;          // Timeout counter
  localparam logic [IDX_W-1:0] RST_IDX [11] = '{IDX_SB_LO, IDX_SB_HI, IDX_SA_LO, IDX_SA_HI,
    IDX_SHORT_CTL, IDX_LONG_CTL, IDX_LONG_LO, IDX_LONG_MID, IDX_LONG_TOP, IDX_EVT_STAT,
    IDX_EVT_MASK};
  rft_timers dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOscIn(fastOscIn), .slowOscIn(slowOscIn), .shortAIrq(shortAIrq),
    .shortBIrq(shortBIrq), .longIrq(longIrq), .irq(irq));
  // ----------------------------------------------------------------
  // Clock, oscillators (fast period 4 cycles, slow 16) and timeout
  // ----------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    oscCnt <= oscCnt + 4'h1;
    fastOscIn <= oscCnt[1];
    slowOscIn <= oscCnt[3];
    cycles++;
    if (cycles == 6000) begin
      numErrors++;
      tallyAndFinish();
    end
  end
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic [IDX_W-1:0] idx, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic chkRd(input logic [IDX_W-1:0] idx, input logic [7:0] e, input string nm);
    apb(idx, 1'b0, 8'h00);
    `CHK(nm, e, rdat)
  endtask
  task automatic tallyAndFinish();
    if (numErrors == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (RST_IDX[i]) chkRd(RST_IDX[i], 8'h00, "reset value");
    // First short timer, free-running, overflow and wrap to zero
    wr(IDX_SA_HI, 8'hff);
    wr(IDX_SA_LO, 8'hf0);
    wr(IDX_SHORT_CTL, 8'h03);
    repeat (40) @(posedge sys_clk);
    `CHK("shortAIrq", 1'b1, shortAIrq)
    `CHK("irq masked", 1'b0, irq)
    chkRd(IDX_SHORT_CTL, 8'h0b, "short ctl flag A");
    wr(IDX_EVT_MASK, 8'h01);
    `CHK("irq unmasked", 1'b1, irq)
    wr(IDX_SHORT_CTL, 8'h01);
    `CHK("shortAIrq clear", 1'b0, shortAIrq)
    chkRd(IDX_SA_HI, 8'h00, "A wrapped high");
    chkRd(IDX_SA_LO, 8'h21, "A stopped low");
    repeat (5) @(posedge sys_clk);
    chkRd(IDX_SA_LO, 8'h21, "A held while stopped");
    chkRd(IDX_EVT_STAT, 8'h01, "event status");
    chkRd(IDX_EVT_STAT, 8'h00, "event status cleared");
    `CHK("irq after clear", 1'b0, irq)
    // Second short timer, auto-reload
    wr(IDX_SB_HI, 8'hff);
    wr(IDX_SB_LO, 8'hf0);
    wr(IDX_SHORT_CTL, 8'h40);
    wr(IDX_SB_HI, 8'hab);
    wr(IDX_SB_LO, 8'h00);
    chkRd(IDX_SB_HI, 8'hff, "B counter kept");
    wr(IDX_SHORT_CTL, 8'h70);
    repeat (40) @(posedge sys_clk);
    `CHK("shortBIrq", 1'b1, shortBIrq)
    chkRd(IDX_SHORT_CTL, 8'hf0, "short ctl flag B");
    wr(IDX_SHORT_CTL, 8'h40);
    chkRd(IDX_SB_HI, 8'hab, "B reloaded");
    // Long timer, auto-reload from fast oscillator
    wr(IDX_LONG_TOP, 8'hff);
    wr(IDX_LONG_MID, 8'hff);
    wr(IDX_LONG_LO, 8'hf0);
    wr(IDX_LONG_CTL, 8'h10);
    wr(IDX_LONG_TOP, 8'h55);
    wr(IDX_LONG_MID, 8'h00);
    wr(IDX_LONG_LO, 8'h00);
    chkRd(IDX_LONG_TOP, 8'hff, "long counter kept");
    wr(IDX_LONG_CTL, 8'h19);
    repeat (150) @(posedge sys_clk);
    `CHK("longIrq", 1'b1, longIrq)
    chkRd(IDX_LONG_CTL, 8'h99, "long ctl flag");
    chkRd(IDX_LONG_TOP, 8'h55, "long reloaded");
    wr(IDX_EVT_MASK, 8'h04);
    `CHK("irq long", 1'b1, irq)
    chkRd(IDX_EVT_STAT, 8'h06, "event B and long");
    wr(IDX_LONG_CTL, 8'h06);
    chkRd(IDX_LONG_CTL, 8'h00, "long unused bits");
    // Every clock select code, tick rate of fast versus slow
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      wr(IDX_LONG_CTL, 8'h00);
      wr(IDX_LONG_LO, 8'h00);
      wr(IDX_LONG_MID, 8'h00);
      wr(IDX_LONG_CTL, {1'b0, sel, 5'h08});
      repeat (160) @(posedge sys_clk);
      wr(IDX_LONG_CTL, {1'b0, sel, 5'h00});
      chkRd(IDX_LONG_CTL, {1'b0, sel, 5'h00}, "long select kept");
      apb(IDX_LONG_LO, 1'b0, 8'h00);
      `CHK("tick rate", 1'b1, sel[1] ? rdat inside {[8:14]} : rdat inside {[38:50]})
    end
    // Unmapped address refused
    chkRd(16'h0200, 8'h00, "unmapped read");
    `CHK("unmapped pslverr", 1'b1, rerr)
    tallyAndFinish();
  end
endmodule
`default_nettype wire
